/* File: scc_clock_ctrl.sv */
// Oscillator control, clock source select and gear registers.
// Assumes a single-cycle strobe bus on clk_sys and synchronous srst.
// Function
// RQ1: Oscillator enables stop when 0, run when 1; fast resets 1, slow 0.
// RQ2: Writing 1 to warm-up bit starts the warm-up timer; 0 does nothing.
// RQ3: Warm-up bit reads 1 while timer counts, 0 once finished.
// RQ4: Status flag reads 0 on fast clock, 1 on slow, after switch-over.
// RQ5: Unused bits read zero and ignore writes.
// RQ6: Post-stop enables choose which oscillator runs after stop release.
// RQ7: Source switch only taken while both oscillator enables are 1.
// RQ8: Oscillator of the selected source always runs after stop release.
// RQ9: Fast gear divides by 3/4, 1/2, 1/4, 1/8; reset selects 1/8.
// RQ10: Prescaler select gives /16, /8, /4, /2; resets to /16.
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_clock_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port, full 32-bit address decoded
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Standby interface
  input wire logic stop_release,
  // Oscillator and clock outputs
  output logic hs_osc_run,
  output logic ls_osc_run,
  output logic on_slow_clock,
  output logic gear_tick,
  output logic prescale_tick,
  output logic slow_gear_half,
  output logic periph_from_fast
);
  logic hs_osc_enable_reg, hs_osc_enable_next;
  logic ls_osc_enable_reg, ls_osc_enable_next;
  logic hs_osc_after_stop_reg, hs_osc_after_stop_next;
  logic ls_osc_after_stop_reg, ls_osc_after_stop_next;
  logic [1:0] prescale_sel_reg, prescale_sel_next;
  logic clock_source_select_reg, clock_source_select_next;
  logic periph_source_select_reg, periph_source_select_next;
  logic slow_gear_select_reg, slow_gear_select_next;
  logic [2:0] fast_gear_reg, fast_gear_next;
  logic [15:0] warmup_timer_reg, warmup_timer_next;
  logic [3:0] sw_cnt_reg, sw_cnt_next;
  scc_pkg::scc_state_t state_reg, state_next;
  logic clock_source_flag;
  logic [7:0] rdata_reg, rdata_next;
  logic gear_tick_w, pre_tick_w;
  logic gear_tick_reg, pre_tick_reg;

  // Address decode, shared by read and write paths
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction : hit

  // Register write logic
  always_comb begin
    hs_osc_enable_next = hs_osc_enable_reg;
    ls_osc_enable_next = ls_osc_enable_reg;
    hs_osc_after_stop_next = hs_osc_after_stop_reg;
    ls_osc_after_stop_next = ls_osc_after_stop_reg;
    prescale_sel_next = prescale_sel_reg;
    clock_source_select_next = clock_source_select_reg;
    periph_source_select_next = periph_source_select_reg;
    slow_gear_select_next = slow_gear_select_reg;
    fast_gear_next = fast_gear_reg;
    if (wr && hit(addr, `SCC_ADDR_OSC)) begin
      hs_osc_enable_next = wdata[`SCC_B_HS_EN]; // see RQ1
      ls_osc_enable_next = wdata[`SCC_B_LS_EN]; // see RQ1
      hs_osc_after_stop_next = wdata[`SCC_B_HS_AS]; // see RQ6
      ls_osc_after_stop_next = wdata[`SCC_B_LS_AS]; // see RQ6
      prescale_sel_next = wdata[1:0]; // see RQ10
    end
    if (wr && hit(addr, `SCC_ADDR_SEL)) begin
      if (hs_osc_enable_reg && ls_osc_enable_reg) begin
        clock_source_select_next = wdata[`SCC_B_CSEL]; // see RQ7
      end
      periph_source_select_next = wdata[`SCC_B_PSEL];
      slow_gear_select_next = wdata[`SCC_B_SLOW_GEAR_SELECT];
      fast_gear_next = wdata[2:0]; // see RQ9
    end
    // Stop release: each oscillator follows its post-stop bit, except that the selected source's oscillator stays on
    if (stop_release) begin
      hs_osc_enable_next = hs_osc_after_stop_reg
        || !clock_source_select_reg; // see RQ6 see RQ8
      ls_osc_enable_next = ls_osc_after_stop_reg
        || clock_source_select_reg; // see RQ6 see RQ8
    end
  end

  // Warm-up timer: a write of 1 loads, a write of 0 is ignored
  always_comb begin
    warmup_timer_next = warmup_timer_reg;
    if (warmup_timer_reg != `SCC_ZERO16) begin
      warmup_timer_next = warmup_timer_reg - `SCC_ONE16;
    end
    if (wr && hit(addr, `SCC_ADDR_OSC) && wdata[`SCC_B_WU]) begin
      warmup_timer_next = `SCC_WARMUP_CYCLES; // see RQ2
    end
  end

  // Source switch-over sequence; the flag moves only once it is done
  always_comb begin
    state_next = state_reg;
    sw_cnt_next = sw_cnt_reg;
    case (state_reg)
      scc_pkg::SCC_ST_FAST: begin
        if (clock_source_select_reg) begin
          state_next = scc_pkg::SCC_ST_TO_SLOW;
          sw_cnt_next = `SCC_SWITCH_CYCLES;
        end
      end
      scc_pkg::SCC_ST_TO_SLOW: begin
        sw_cnt_next = sw_cnt_reg - `SCC_ONE4;
        if (sw_cnt_reg == `SCC_ONE4) begin
          state_next = scc_pkg::SCC_ST_SLOW;
        end
      end
      scc_pkg::SCC_ST_SLOW: begin
        if (!clock_source_select_reg) begin
          state_next = scc_pkg::SCC_ST_TO_FAST;
          sw_cnt_next = `SCC_SWITCH_CYCLES;
        end
      end
      scc_pkg::SCC_ST_TO_FAST: begin
        sw_cnt_next = sw_cnt_reg - `SCC_ONE4;
        if (sw_cnt_reg == `SCC_ONE4) begin
          state_next = scc_pkg::SCC_ST_FAST;
        end
      end
      default: state_next = scc_pkg::SCC_ST_FAST;
    endcase
  end

  // Flag is high in the slow state and while leaving it
  assign clock_source_flag = (state_reg == scc_pkg::SCC_ST_SLOW)
    || (state_reg == scc_pkg::SCC_ST_TO_FAST); // see RQ4

  // Read data, valid the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (rd && hit(addr, `SCC_ADDR_OSC)) begin
      rdata_next[`SCC_B_HS_EN] = hs_osc_enable_reg;
      rdata_next[`SCC_B_LS_EN] = ls_osc_enable_reg;
      rdata_next[`SCC_B_HS_AS] = hs_osc_after_stop_reg;
      rdata_next[`SCC_B_LS_AS] = ls_osc_after_stop_reg;
      rdata_next[`SCC_B_WU] = (warmup_timer_reg != `SCC_ZERO16); // see RQ3
      rdata_next[1:0] = prescale_sel_reg;
    end
    if (rd && hit(addr, `SCC_ADDR_SEL)) begin
      rdata_next[`SCC_B_CFLG] = clock_source_flag; // see RQ4
      rdata_next[`SCC_B_CSEL] = clock_source_select_reg;
      rdata_next[`SCC_B_PSEL] = periph_source_select_reg;
      rdata_next[`SCC_B_SLOW_GEAR_SELECT] = slow_gear_select_reg;
      rdata_next[2:0] = fast_gear_reg;
    end
    // Bit 3 of one, bit 7 of the other stay zero; see RQ5
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hs_osc_enable_reg <= 1'b1; // see RQ1
      ls_osc_enable_reg <= 1'b0;
      hs_osc_after_stop_reg <= 1'b1;
      ls_osc_after_stop_reg <= 1'b0;
      prescale_sel_reg <= 2'h0;
      clock_source_select_reg <= 1'b0;
      periph_source_select_reg <= 1'b0;
      slow_gear_select_reg <= 1'b0;
      fast_gear_reg <= `SCC_GEAR_8;
      warmup_timer_reg <= `SCC_ZERO16;
      sw_cnt_reg <= `SCC_ZERO4;
      state_reg <= scc_pkg::SCC_ST_FAST;
      rdata_reg <= 8'h00;
      gear_tick_reg <= 1'b0;
      pre_tick_reg <= 1'b0;
    end else begin
      hs_osc_enable_reg <= hs_osc_enable_next;
      ls_osc_enable_reg <= ls_osc_enable_next;
      hs_osc_after_stop_reg <= hs_osc_after_stop_next;
      ls_osc_after_stop_reg <= ls_osc_after_stop_next;
      prescale_sel_reg <= prescale_sel_next;
      clock_source_select_reg <= clock_source_select_next;
      periph_source_select_reg <= periph_source_select_next;
      slow_gear_select_reg <= slow_gear_select_next;
      fast_gear_reg <= fast_gear_next;
      warmup_timer_reg <= warmup_timer_next;
      sw_cnt_reg <= sw_cnt_next;
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      gear_tick_reg <= gear_tick_w;
      pre_tick_reg <= pre_tick_w;
    end
  end

  // Gear and prescaler ticks
  scc_divider u_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .gear(fast_gear_reg), // see RQ9
    .pre(prescale_sel_reg), // see RQ10
    .gear_tick(gear_tick_w),
    .pre_tick(pre_tick_w)
  );

  // Outputs straight from flip-flops
  assign rdata = rdata_reg;
  assign hs_osc_run = hs_osc_enable_reg;
  assign ls_osc_run = ls_osc_enable_reg;
  assign on_slow_clock = state_reg[1];
  assign gear_tick = gear_tick_reg;
  assign prescale_tick = pre_tick_reg;
  assign slow_gear_half = slow_gear_select_reg;
  assign periph_from_fast = periph_source_select_reg;
endmodule : scc_clock_ctrl

/* File: scc_clock_ctrl_sva.sv */
// Port checker for the clock control registers.
// Assumes a bind onto scc_clock_ctrl, one clock, synchronous srst.
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_clock_ctrl_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic stop_release,
  // Watched outputs
  input wire logic hs_osc_run,
  input wire logic ls_osc_run,
  input wire logic on_slow_clock,
  input wire logic gear_tick,
  input wire logic prescale_tick,
  input wire logic slow_gear_half,
  input wire logic periph_from_fast
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Reset values, register writes, read port and switch timing
  chk_reset_vals: assert property (
    $fell(srst) |-> hs_osc_run && !ls_osc_run && !on_slow_clock && !gear_tick
  ) else $error("reset values wrong");
  chk_rdata_idle: assert property (
    !$past(rd) |-> rdata == 8'h00) else $error("rdata not zero when idle");
  chk_unmapped_rd: assert property (
    rd && addr != `SCC_ADDR_OSC && addr != `SCC_ADDR_SEL |=> rdata == 8'h00
  ) else $error("unmapped read not zero");
  chk_osc_write: assert property (
    wr && addr == `SCC_ADDR_OSC && !stop_release |=>
    hs_osc_run == $past(wdata[7]) && ls_osc_run == $past(wdata[6])
  ) else $error("enable write not taken");
  chk_sel_write: assert property (
    wr && addr == `SCC_ADDR_SEL |=> periph_from_fast == $past(wdata[4]) &&
    slow_gear_half == $past(wdata[3])) else $error("select write not taken");
  chk_switch_slow: assert property (
    wr && addr == `SCC_ADDR_SEL && wdata[5] && hs_osc_run && ls_osc_run &&
    !on_slow_clock && !stop_release |-> ##6 on_slow_clock
  ) else $error("switch to slow clock late");
  chk_switch_block: assert property (
    wr && addr == `SCC_ADDR_SEL && wdata[5] && !ls_osc_run && !on_slow_clock
    |=> !on_slow_clock [*6]) else $error("switch taken with oscillator off");
  chk_stop_keep: assert property (
    stop_release && !on_slow_clock && !ls_osc_run |=> hs_osc_run
  ) else $error("selected oscillator stopped after stop release");
  chk_pre_pulse: assert property (
    prescale_tick |=> !prescale_tick) else $error("prescale tick too long");
endmodule : scc_clock_ctrl_sva

bind scc_clock_ctrl scc_clock_ctrl_sva chk_u (.clk_sys(clk_sys), .srst(srst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .stop_release(stop_release), .hs_osc_run(hs_osc_run),
  .ls_osc_run(ls_osc_run), .on_slow_clock(on_slow_clock),
  .gear_tick(gear_tick), .prescale_tick(prescale_tick),
  .slow_gear_half(slow_gear_half), .periph_from_fast(periph_from_fast));

/* File: scc_divider.sv */
// Gear and prescaler enable generator for the clock control.
// Assumes one clock; emits one-cycle tick enables from codes.
`timescale 1ns/1ps
module scc_divider (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Division codes
  input wire logic [2:0] gear,
  input wire logic [1:0] pre,
  // Tick outputs
  output logic gear_tick,
  output logic pre_tick
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic gear_reg;
  logic gear_next;
  logic [3:0] pcnt_reg;
  logic [3:0] pcnt_next;
  logic pre_reg;
  logic pre_next;

  // Gear: 3/4 drops every fourth tick, the other defined codes divide by a power of two
  always_comb begin
    cnt_next = cnt_reg + `SCC_ONE4;
    case (gear)
      `SCC_GEAR_FC: gear_next = 1'b1;
      `SCC_GEAR_34: gear_next = (cnt_reg[1:0] != 2'b11);
      `SCC_GEAR_2: gear_next = (cnt_reg[0] == 1'b1);
      `SCC_GEAR_4: gear_next = (cnt_reg[1:0] == 2'b11);
      `SCC_GEAR_8: gear_next = (cnt_reg[2:0] == 3'b111);
      default: gear_next = 1'b0; // Reserved codes stall the gear
    endcase
    pcnt_next = pcnt_reg;
    pre_next = 1'b0;
    if (gear_reg) begin
      pcnt_next = pcnt_reg + `SCC_ONE4;
      case (pre)
        2'b00: pre_next = (pcnt_reg == 4'hf);
        2'b01: pre_next = (pcnt_reg[2:0] == 3'h7);
        2'b10: pre_next = (pcnt_reg[1:0] == 2'h3);
        default: pre_next = pcnt_reg[0];
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= `SCC_ZERO4;
      gear_reg <= 1'b0;
      pcnt_reg <= `SCC_ZERO4;
      pre_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      gear_reg <= gear_next;
      pcnt_reg <= pcnt_next;
      pre_reg <= pre_next;
    end
  end

  assign gear_tick = gear_reg;
  assign pre_tick = pre_reg;
endmodule : scc_divider

/* File: scc_map.svh */
// Register map, field positions, reset values and timing of the clock control.
// Assumes inclusion by bare name from the top module, the checker and the bench.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_ADDR_OSC 32'hffff_ee00
`define SCC_ADDR_SEL 32'hffff_ee01
`define SCC_OSC_RESET 8'h00a0
`define SCC_SEL_RESET 8'h0007
`define SCC_B_HS_EN 7
`define SCC_B_LS_EN 6
`define SCC_B_HS_AS 5
`define SCC_B_LS_AS 4
`define SCC_B_WU 2
`define SCC_B_CFLG 6
`define SCC_B_CSEL 5
`define SCC_B_PSEL 4
`define SCC_B_SLOW_GEAR_SELECT 3
`define SCC_GEAR_FC 3'h0
`define SCC_GEAR_34 3'h2
`define SCC_GEAR_2 3'h4
`define SCC_GEAR_4 3'h6
`define SCC_GEAR_8 3'h7
`define SCC_WARMUP_CYCLES 16'h4000
`define SCC_SWITCH_CYCLES 4'h4
`define SCC_ZERO16 16'h0000
`define SCC_ONE16 16'h0001
`define SCC_ZERO4 4'h0
`define SCC_ONE4 4'h1
`endif

/* File: scc_pkg.sv */
// Types shared by the clock control files.
// Assumes scc_map.svh is on the include path.
package scc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scc_req_t;
  typedef enum logic [1:0] {
    SCC_ST_FAST = 2'b00,
    SCC_ST_TO_SLOW = 2'b01,
    SCC_ST_SLOW = 2'b10,
    SCC_ST_TO_FAST = 2'b11
  } scc_state_t;
endpackage : scc_pkg

/* File: system_clock_control_regs_tb.sv */
// Self-checking bench for the clock control registers.
// Assumes the design files and scc_map.svh are compiled before it.
`timescale 1ns/1ps
`include "scc_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module system_clock_control_regs_tb;
  logic clk_sys = 0, srst = 1, wr = 0, rd = 0, stop_release = 0;
  logic [31:0] addr = 32'h0000_0000;
  logic [7:0] wdata = 8'h00, rdata, rv, n;
  logic hs_osc_run, ls_osc_run, on_slow_clock, gear_tick, prescale_tick;
  logic slow_gear_half, periph_from_fast;
  int err_total = 0, n_tests = 0, cyc = 0, i, t0;
  // Design under test
  scc_clock_ctrl dut_u (.clk_sys(clk_sys), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .stop_release(stop_release), .hs_osc_run(hs_osc_run),
    .ls_osc_run(ls_osc_run), .on_slow_clock(on_slow_clock),
    .gear_tick(gear_tick), .prescale_tick(prescale_tick),
    .slow_gear_half(slow_gear_half), .periph_from_fast(periph_from_fast));
  // Clock and cycle count
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // Bus cycles
  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk_sys);
    wr <= 0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [31:0] a);
    @(posedge clk_sys);
    addr <= a; rd <= 1;
    @(posedge clk_sys);
    rd <= 0;
    #1 rv = rdata;
  endtask : rd_reg
  task automatic wait_slow(input logic v);
    for (i = 0; i < 20 && on_slow_clock !== v; i++) @(posedge clk_sys) #1;
    if (i == 20) begin err_total++; stop_test(); end
  endtask : wait_slow
  task automatic stop_pulse;
    @(posedge clk_sys) stop_release <= 1;
    @(posedge clk_sys) stop_release <= 0;
    #1;
  endtask : stop_pulse
  task automatic count64(input logic which);
    n = 8'h00;
    repeat (16) @(posedge clk_sys);
    repeat (64) begin
      @(posedge clk_sys) #1;
      n = n + (which ? prescale_tick : gear_tick);
    end
  endtask : count64
  // Scenarios
  task automatic t_reset;
    rd_reg(`SCC_ADDR_OSC); `CHK(rv, 8'ha0)
    rd_reg(`SCC_ADDR_SEL); `CHK(rv, 8'h07)
    $display("test reset done");
  endtask : t_reset
  task automatic t_unused;
    wr_reg(`SCC_ADDR_OSC, 8'hfb);
    wr_reg(`SCC_ADDR_SEL, 8'hdf);
    rd_reg(`SCC_ADDR_OSC); `CHK(rv, 8'hf3)
    `CHK(rv[2], 1'b0)
    rd_reg(`SCC_ADDR_SEL); `CHK(rv, 8'h1f)
    rd_reg(32'hffff_ee02); `CHK(rv, 8'h00)
    `CHK({slow_gear_half, periph_from_fast}, 2'b11)
    wr_reg(`SCC_ADDR_SEL, 8'h07);
    $display("test unused done");
  endtask : t_unused
  task automatic t_warmup;
    wr_reg(`SCC_ADDR_OSC, 8'hf7);
    t0 = cyc;
    rd_reg(`SCC_ADDR_OSC); `CHK(rv[2], 1'b1)
    // A zero written to the warm-up bit mid-count must not stop the timer
    wr_reg(`SCC_ADDR_OSC, 8'hf3);
    rd_reg(`SCC_ADDR_OSC); `CHK(rv[2], 1'b1)
    for (i = 0; i < 9000 && rv[2] === 1'b1; i++) rd_reg(`SCC_ADDR_OSC);
    if (i == 9000) begin err_total++; stop_test(); end
    `CHK(cyc - t0 >= 16384 && cyc - t0 <= 16392, 1'b1)
    $display("test warmup done");
  endtask : t_warmup
  task automatic t_switch;
    wr_reg(`SCC_ADDR_SEL, 8'h27);
    wait_slow(1'b1);
    rd_reg(`SCC_ADDR_SEL); `CHK(rv, 8'h67)
    wr_reg(`SCC_ADDR_SEL, 8'h07);
    wait_slow(1'b0);
    rd_reg(`SCC_ADDR_SEL); `CHK(rv, 8'h07)
    wr_reg(`SCC_ADDR_OSC, 8'hb3);
    wr_reg(`SCC_ADDR_SEL, 8'h27);
    repeat (8) @(posedge clk_sys);
    rd_reg(`SCC_ADDR_SEL); `CHK(rv, 8'h07)
    $display("test switch done");
  endtask : t_switch
  task automatic t_stop;
    wr_reg(`SCC_ADDR_OSC, 8'h83);
    stop_pulse(); `CHK({hs_osc_run, ls_osc_run}, 2'b10)
    wr_reg(`SCC_ADDR_OSC, 8'h13);
    stop_pulse(); `CHK({hs_osc_run, ls_osc_run}, 2'b11)
    $display("test stop done");
  endtask : t_stop
  task automatic t_gear;
    logic [2:0] gc [6] = '{`SCC_GEAR_FC, `SCC_GEAR_34, `SCC_GEAR_2,
      `SCC_GEAR_4, `SCC_GEAR_8, 3'h1};
    logic [7:0] ge [6] = '{8'h40, 8'h30, 8'h20, 8'h10, 8'h08, 8'h00};
    for (int k = 0; k < 6; k++) begin
      wr_reg(`SCC_ADDR_SEL, {5'h00, gc[k]});
      count64(1'b0); `CHK(n, ge[k])
    end
    wr_reg(`SCC_ADDR_SEL, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr_reg(`SCC_ADDR_OSC, 8'hf0 | 8'(p));
      count64(1'b1); `CHK(n, 8'h04 << p)
    end
    $display("test gear done");
  endtask : t_gear
  // Reset in mid-run while on the slow clock restores every default
  task automatic t_rerst;
    wr_reg(`SCC_ADDR_SEL, 8'h27);
    wait_slow(1'b1);
    @(posedge clk_sys) srst <= 1;
    repeat (5) @(posedge clk_sys);
    srst <= 0;
    #1;
    `CHK({hs_osc_run, ls_osc_run}, 2'b10)
    `CHK(on_slow_clock, 1'b0)
    rd_reg(`SCC_ADDR_OSC); `CHK(rv, 8'ha0)
    rd_reg(`SCC_ADDR_SEL); `CHK(rv, 8'h07)
    $display("test mid-run reset done");
  endtask : t_rerst
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 0;
    t_reset();
    t_unused();
    t_warmup();
    t_switch();
    t_stop();
    t_gear();
    t_rerst();
    stop_test();
  end
endmodule : system_clock_control_regs_tb
